// File: ptm_pkg.sv
// package of constants, types and register map for the periodic timer block
// What this block does
// - compare mode: match sets none/low/high/toggle
// - pwm mode: inactive, active, pwm, single pulse
// - wide capture, no clear: edge into compare a
// - clear select set: edges split into a/b
// - narrow capture: clock pin edges select capture
// - same level as initial gives no change
// - run rising edge restores initial pin level
// - level bit: initial level or active level
// - single pulse: level bit applies at run rise
// - invert bit inverts output, not in timer mode
// - capture source: capture pin, clock pin, filter
// - clear select: compare a, else period/overflow
// - clear select ignored in pwm/pulse/capture modes
// - capture clear: period match plus edge clears
// - read-only flag shows latest latch edge
// - counter readable only, low and high bytes
// - compare a read/write, bytes reset zero
// - period read/write, bytes reset zero
// - second capture register only on first instance
// - unimplemented bits read as zero
// - mode field: compare, capture, pwm, timer
// - run rise clears counter, fall holds it
package ptm_pkg;
    // register indices, byte address is four times the index
    localparam logic [3:0] PTM_IDX_RUN    = 4'h0; // run control register
    localparam logic [3:0] PTM_IDX_PINCTL = 4'h1; // pin_output_control
    localparam logic [3:0] PTM_IDX_CAPCLR = 4'h2; // capture_clear_control
    localparam logic [3:0] PTM_IDX_CNTL   = 4'h3; // count_low
    localparam logic [3:0] PTM_IDX_CNTH   = 4'h4; // count_high
    localparam logic [3:0] PTM_IDX_CMPAL  = 4'h5; // compare_a_low
    localparam logic [3:0] PTM_IDX_CMPAH  = 4'h6; // compare_a_high
    localparam logic [3:0] PTM_IDX_CAPBL  = 4'h7; // capture_b_low
    localparam logic [3:0] PTM_IDX_CAPBH  = 4'h8; // capture_b_high
    localparam logic [3:0] PTM_IDX_PERL   = 4'h9; // period_low
    localparam logic [3:0] PTM_IDX_PERH   = 4'hA; // period_high
    // field positions inside the pin control byte
    localparam int PTM_F_MODE_HI = 7; // operating mode msb
    localparam int PTM_F_MODE_LO = 6; // operating mode lsb
    localparam int PTM_F_PFS_HI  = 5; // pin function msb
    localparam int PTM_F_PFS_LO  = 4; // pin function lsb
    localparam int PTM_F_OLC     = 3; // output level control
    localparam int PTM_F_INV     = 2; // output invert
    localparam int PTM_F_CSRC    = 1; // capture source select
    localparam int PTM_F_CCLR    = 0; // counter clear select
    localparam logic [7:0] PTM_RESET_BYTE = 8'h00; // reset of every byte
    localparam logic [2:0] PTM_CAPCLR_MASK = 3'h6; // writable capture clear bits
    // operating modes
    typedef enum logic [1:0] {
        PTM_MODE_CMP = 2'h0, // compare match output
        PTM_MODE_CAP = 2'h1, // capture input
        PTM_MODE_PWM = 2'h2, // pwm or single pulse
        PTM_MODE_TMR = 2'h3  // timer/counter
    } ptm_mode_type;
    // pin function codes
    localparam logic [1:0] PTM_PF_00 = 2'h0; // none / inactive / rising
    localparam logic [1:0] PTM_PF_01 = 2'h1; // low / active / falling
    localparam logic [1:0] PTM_PF_10 = 2'h2; // high / pwm / both
    localparam logic [1:0] PTM_PF_11 = 2'h3; // toggle / pulse / disabled
    localparam logic [1:0] PTM_TC_00 = 2'h0; // period match clear only
    localparam logic [1:0] PTM_TC_01 = 2'h1; // plus rising clear
    localparam logic [1:0] PTM_TC_10 = 2'h2; // plus falling clear
    // bus answer states
    typedef enum logic [1:0] {
        PTM_BUS_IDLE = 2'b01, // waiting for request
        PTM_BUS_ACK  = 2'b10  // answer cycle
    } ptm_bus_type;
endpackage : ptm_pkg

// File: ptm_edge_if.sv
// interface carrying sampled edge events from the edge detector
`timescale 1ns/100ps
`default_nettype none
interface ptm_edge_if;
    logic rise; // rising edge seen this cycle
    logic fall; // falling edge seen this cycle
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface : ptm_edge_if
`default_nettype wire

// File: ptm_edge_det.sv
// edge detector for one synchronous input
`timescale 1ns/100ps
`default_nettype none
module ptm_edge_det (
    input  wire logic   ref_clk,
    input  wire logic   nrst,
    input  wire logic   sig_in,
    ptm_edge_if.src     edg
);
    // previous sample
    typedef struct packed {
        logic prev;
    } ptm_edet_type;
    ptm_edet_type st_r;
    ptm_edet_type st_nxt;
    // next state is the current sample
    always_comb begin
        st_nxt.prev = sig_in;
    end
    // register the sample
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign edg.rise = sig_in & ~st_r.prev; // low to high
    assign edg.fall = ~sig_in & st_r.prev; // high to low
endmodule : ptm_edge_det
`default_nettype wire

// File: ptm_timer.sv
// periodic timer with pin, compare and capture control and avalon slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ptm_timer
    import ptm_pkg::*;
#(
    parameter int CNT_W   = 16, // counter width, 16 or 10
    parameter bit HAS_CAPB = 1'b1 // second capture register present
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    input  wire logic        count_tick,
    input  wire logic        capture_input_pin,
    input  wire logic        external_clock_pin,
    input  wire logic        filter_out,
    input  wire logic        filter_source_select,
    output logic             timer_out,
    output logic             match_a_pulse,
    output logic             match_p_pulse
);
    // elaboration check of widths
    if (!(CNT_W == 16 || CNT_W == 10)) begin : g_chk
        $error("CNT_W must be 16 or 10");
    end
    if (HAS_CAPB && CNT_W != 16) begin : g_chk2
        $error("second capture needs 16 bits");
    end

    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}}; // overflow value
    localparam int HI_W = CNT_W - 8; // high byte width

    // all state of the block except the edge detector sample
    typedef struct packed {
        ptm_bus_type       bus;    // bus answer state
        logic [31:0]       rdata;  // read data
        logic              run;    // run control
        logic [7:0]        pinctl; // pin_output_control
        logic [1:0]        tclr;   // capture clear select
        logic              vlf;    // latch edge flag
        logic [CNT_W-1:0]  cnt;    // counter
        logic [CNT_W-1:0]  cmpa;   // compare a
        logic [CNT_W-1:0]  per;    // period
        logic [CNT_W-1:0]  capb;   // second capture value
        logic              pin;    // pre-invert output level
        logic              pwm;    // pwm waveform level
        logic              out;    // registered pin
        logic              ma;     // compare a match pulse
        logic              mp;     // compare p match pulse
    } ptm_state_type;
    ptm_state_type st_r;
    ptm_state_type st_nxt;

    ptm_edge_if cap_edg (); // selected capture source edges
    logic cap_src; // chosen capture source

    // capture source selection
    always_comb begin
        if (CNT_W == 16) begin
            cap_src = st_r.pinctl[PTM_F_CSRC] ?
                      (filter_source_select ? filter_out : external_clock_pin) :
                      capture_input_pin;
        end else begin
            cap_src = external_clock_pin;
        end
    end

    // edge detector on capture source
    ptm_edge_det u_cap_edge (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .sig_in  (cap_src),
        .edg     (cap_edg)
    );

    logic [1:0]       mode;   // operating mode
    logic [1:0]       pfs;    // pin function select
    logic             olc;    // output level control
    logic             sel;    // bus selects this block
    logic [7:0]       wb;     // written byte
    logic             wr_run; // write to run register
    logic [CNT_W-1:0] cnt_q;  // counter after stepping
    logic             wr_ok;  // write taken this cycle
    logic             cap_a;  // latch into compare a
    logic             cap_b;  // latch into second capture
    logic             eclr;   // capture edge clear
    logic             mat_a;  // compare a match
    logic             mat_p;  // compare p match
    logic             ovf;    // overflow
    logic             clr;    // counter clear
    logic             run_rise; // run control rising
    logic             new_run;  // next run value
    logic [7:0]       rbyte;  // read byte

    // next-state logic
    always_comb begin
        st_nxt  = st_r;
        mode    = st_r.pinctl[PTM_F_MODE_HI:PTM_F_MODE_LO];
        pfs     = st_r.pinctl[PTM_F_PFS_HI:PTM_F_PFS_LO];
        olc     = st_r.pinctl[PTM_F_OLC];
        sel     = avs_read | avs_write;
        wb      = avs_writedata[7:0];
        wr_ok   = avs_write & avs_byteenable[0] & (st_r.bus == PTM_BUS_IDLE);
        wr_run  = wr_ok & (avs_address == PTM_IDX_RUN);
        cap_a   = 1'b0;
        cap_b   = 1'b0;
        eclr    = 1'b0;
        rbyte   = PTM_RESET_BYTE;
        new_run = wr_run ? wb[0] : st_r.run;
        // comparators on current count
        mat_a = st_r.run & count_tick & (st_r.cnt == st_r.cmpa);
        mat_p = st_r.run & count_tick & (st_r.cnt == st_r.per);
        ovf   = st_r.run & count_tick & (st_r.cnt == CNT_MAX);
        // capture edges
        if (mode == PTM_MODE_CAP && st_r.run) begin
            if (CNT_W == 16 && st_r.tclr == PTM_TC_00) begin
                unique case (pfs)
                    PTM_PF_00: cap_a = cap_edg.rise;
                    PTM_PF_01: cap_a = cap_edg.fall;
                    PTM_PF_10: cap_a = cap_edg.rise | cap_edg.fall;
                    PTM_PF_11: cap_a = 1'b0;
                endcase
            end else if (CNT_W == 16) begin
                unique case (pfs)
                    PTM_PF_00: cap_b = cap_edg.rise;
                    PTM_PF_01: cap_a = cap_edg.fall;
                    PTM_PF_10: begin
                        cap_a = cap_edg.fall;
                        cap_b = cap_edg.rise;
                    end
                    PTM_PF_11: cap_a = 1'b0;
                endcase
                cap_b = cap_b & HAS_CAPB;
            end else begin
                unique case (pfs)
                    PTM_PF_00: cap_a = cap_edg.rise;
                    PTM_PF_01: cap_a = cap_edg.fall;
                    PTM_PF_10: cap_a = cap_edg.rise | cap_edg.fall;
                    PTM_PF_11: cap_a = 1'b0;
                endcase
            end
            unique case (st_r.tclr)
                PTM_TC_00: eclr = 1'b0;
                PTM_TC_01: eclr = cap_edg.rise;
                PTM_TC_10: eclr = cap_edg.fall;
                default:   eclr = cap_edg.rise | cap_edg.fall;
            endcase
        end
        // counter clear choice
        if (mode == PTM_MODE_CMP || mode == PTM_MODE_TMR) begin
            clr = st_r.pinctl[PTM_F_CCLR] ? mat_a :
                  ((st_r.per == '0) ? ovf : mat_p);
        end else if (mode == PTM_MODE_CAP) begin
            clr = mat_p | eclr;
        end else begin
            clr = mat_p;
        end
        // counter stepping
        cnt_q = st_r.cnt;
        if (st_r.run && count_tick) begin
            cnt_q = clr ? '0 : st_r.cnt + 1'b1;
        end
        if (eclr) begin
            cnt_q = '0;
        end
        // single pulse stops the run bit on compare a
        if (mode == PTM_MODE_PWM && pfs == PTM_PF_11 && mat_a) begin
            new_run = 1'b0;
        end
        run_rise = new_run & ~st_r.run;
        st_nxt.cnt = run_rise ? '0 : cnt_q;
        st_nxt.run = new_run;
        st_nxt.ma  = mat_a;
        st_nxt.mp  = mat_p;
        // capture latches
        if (cap_a) begin
            st_nxt.cmpa = st_r.cnt;
            st_nxt.vlf  = cap_edg.rise;
        end
        if (cap_b) begin
            st_nxt.capb = st_r.cnt;
            st_nxt.vlf  = 1'b1;
        end
        // pwm waveform, duty at or above period is full
        if (st_r.run && count_tick) begin
            if (clr) begin
                st_nxt.pwm = 1'b1;
            end else if (mat_a && st_r.cmpa < st_r.per) begin
                st_nxt.pwm = 1'b0;
            end
        end
        // output pin level per mode
        if (run_rise) begin
            st_nxt.pin = olc;
            st_nxt.pwm = 1'b1;
        end else if (mode == PTM_MODE_CMP && mat_a) begin
            unique case (pfs)
                PTM_PF_00: st_nxt.pin = st_r.pin;
                PTM_PF_01: st_nxt.pin = 1'b0;
                PTM_PF_10: st_nxt.pin = 1'b1;
                PTM_PF_11: st_nxt.pin = ~st_r.pin;
            endcase
        end else if (mode == PTM_MODE_PWM) begin
            unique case (pfs)
                PTM_PF_00: st_nxt.pin = ~olc;
                PTM_PF_01: st_nxt.pin = olc;
                PTM_PF_10: st_nxt.pin = st_nxt.pwm ? olc : ~olc;
                PTM_PF_11: st_nxt.pin = new_run ? olc : ~olc;
            endcase
        end
        st_nxt.out = (mode == PTM_MODE_TMR) ? 1'b0 :
                     (st_nxt.pin ^ st_r.pinctl[PTM_F_INV]);
        // register writes; software
        if (wr_ok) begin
            unique case (avs_address)
                PTM_IDX_PINCTL: st_nxt.pinctl = wb;
                PTM_IDX_CAPCLR: begin
                    if (HAS_CAPB) begin
                        st_nxt.tclr = wb[2:1];
                    end
                end
                PTM_IDX_CMPAL:  st_nxt.cmpa[7:0] = wb;
                PTM_IDX_CMPAH:  st_nxt.cmpa[CNT_W-1:8] = wb[HI_W-1:0];
                PTM_IDX_PERL:   st_nxt.per[7:0] = wb;
                PTM_IDX_PERH:   st_nxt.per[CNT_W-1:8] = wb[HI_W-1:0];
                PTM_IDX_CAPBL:  begin
                    if (HAS_CAPB) begin
                        st_nxt.capb[7:0] = wb;
                    end
                end
                PTM_IDX_CAPBH:  begin
                    if (HAS_CAPB) begin
                        st_nxt.capb[CNT_W-1:8] = wb[HI_W-1:0];
                    end
                end
                default: st_nxt.rdata = st_nxt.rdata; // counter not writable
            endcase
        end
        // read multiplexer, unused bits zero
        unique case (avs_address)
            PTM_IDX_RUN:    rbyte = {7'h00, st_r.run};
            PTM_IDX_PINCTL: rbyte = st_r.pinctl;
            PTM_IDX_CAPCLR: rbyte = HAS_CAPB ?
                                {5'h00, st_r.tclr, st_r.vlf} : PTM_RESET_BYTE;
            PTM_IDX_CNTL:   rbyte = st_r.cnt[7:0];
            PTM_IDX_CNTH:   rbyte = 8'(st_r.cnt[CNT_W-1:8]);
            PTM_IDX_CMPAL:  rbyte = st_r.cmpa[7:0];
            PTM_IDX_CMPAH:  rbyte = 8'(st_r.cmpa[CNT_W-1:8]);
            PTM_IDX_CAPBL:  rbyte = HAS_CAPB ? st_r.capb[7:0] : PTM_RESET_BYTE;
            PTM_IDX_CAPBH:  rbyte = HAS_CAPB ? 8'(st_r.capb[CNT_W-1:8]) : PTM_RESET_BYTE;
            PTM_IDX_PERL:   rbyte = st_r.per[7:0];
            PTM_IDX_PERH:   rbyte = 8'(st_r.per[CNT_W-1:8]);
            default:        rbyte = PTM_RESET_BYTE;
        endcase
        // bus handshake: one wait cycle then answer
        unique case (st_r.bus)
            PTM_BUS_IDLE: begin
                if (sel) begin
                    st_nxt.bus   = PTM_BUS_ACK;
                    st_nxt.rdata = {24'h00_0000, rbyte};
                end
            end
            PTM_BUS_ACK: begin
                st_nxt.bus = PTM_BUS_IDLE;
            end
            default: st_nxt.bus = PTM_BUS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r     <= '0;
            st_r.bus <= PTM_BUS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    always_comb begin
        avs_readdata    = st_r.rdata;
        avs_waitrequest = (st_r.bus != PTM_BUS_ACK);
        avs_response    = 2'h0;
        timer_out       = st_r.out;
        match_a_pulse   = st_r.ma;
        match_p_pulse   = st_r.mp;
    end
endmodule : ptm_timer
`default_nettype wire

// File: ptm_timer_props.sv
// checker of bus answer and readback rules of the timer
`timescale 1ns/100ps
`default_nettype none
module ptm_timer_props
    import ptm_pkg::*;
#(
    parameter int CNT_W    = 16,  // counter width
    parameter bit HAS_CAPB = 1'b1 // second capture register present
) (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // request taken while slave idle
    sequence req_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // one answer cycle, then idle again
    sequence ans_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    // read of one index taken
    sequence rd_s(logic [3:0] idx);
        avs_read && avs_waitrequest && avs_address == idx;
    endsequence
    wait_answer_a: assert property (req_s |=> ans_s)
        else $error("bus answer not one cycle after request");
    idle_wait_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    resp_okay_a: assert property (avs_response == 2'h0)
        else $error("response code not okay");
    upper_zero_a: assert property (avs_readdata[31:8] == '0)
        else $error("upper read data not zero");
    rdata_hold_a: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
        else $error("read data changed outside answer");
    unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address > 4'hA
        |=> avs_readdata == '0)
        else $error("unmapped read not zero");
    capclr_bits_a: assert property (rd_s(PTM_IDX_CAPCLR) and HAS_CAPB |=> avs_readdata[7:3] == '0)
        else $error("capture clear upper bits not zero");
    narrow_high_a: assert property (CNT_W == 10 && avs_read && avs_waitrequest
        && (avs_address == PTM_IDX_CNTH || avs_address == PTM_IDX_CMPAH
        || avs_address == PTM_IDX_PERH) |=> avs_readdata[7:2] == '0)
        else $error("narrow high byte upper bits not zero");
    no_capb_a: assert property ((rd_s(PTM_IDX_CAPBL) or rd_s(PTM_IDX_CAPBH)) and !HAS_CAPB
        |=> avs_readdata == '0)
        else $error("missing capture register not zero");
endmodule : ptm_timer_props
bind ptm_timer ptm_timer_props #(.CNT_W(CNT_W), .HAS_CAPB(HAS_CAPB)) ptm_timer_props_i (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response));
`default_nettype wire

// File: ptm_pin_model.sv
// model of the sources on the capture and clock pins
`timescale 1ns/100ps
`default_nettype none
module ptm_pin_model (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       sig,                // level for the chosen source
    input  wire logic [1:0] src,                // 0 capture pin, 1 clock pin, 2 filter
    output logic            capture_input_pin,
    output logic            external_clock_pin,
    output logic            filter_out
);
    // unchosen sources show the opposite level, so a wrong pick is seen
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            capture_input_pin  <= 1'b0;
            external_clock_pin <= 1'b0;
            filter_out         <= 1'b0;
        end else begin
            capture_input_pin  <= (src == 2'h0) ? sig : ~sig;
            external_clock_pin <= (src == 2'h1) ? sig : ~sig;
            filter_out         <= (src == 2'h2) ? sig : ~sig;
        end
    end
endmodule : ptm_pin_model
`default_nettype wire

// File: periodic_timer_pin_and_compare_control_tb_top.sv
// self-checking bench of the timer pin and compare control
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module periodic_timer_pin_and_compare_control_tb_top
    import ptm_pkg::*;
;
    logic        ref_clk, nrst, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable, a;
    logic [31:0] avs_writedata, rdata_w, rdata_n, seed;
    logic        count_tick, sig, fss, cap_pin, clk_pin, flt, out_w, ma_w;
    logic [1:0]  src, pf;
    logic [7:0]  q, r, qp;
    int          n_fail, samples_checked, cyc;
    ptm_timer #(.CNT_W(16), .HAS_CAPB(1'b1)) ptm_timer_i (
        .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(rdata_w), .avs_waitrequest(avs_waitrequest), .avs_response(),
        .count_tick(count_tick), .capture_input_pin(cap_pin), .external_clock_pin(clk_pin),
        .filter_out(flt), .filter_source_select(fss), .timer_out(out_w),
        .match_a_pulse(ma_w), .match_p_pulse());
    // narrow instance: only its read data is checked
    ptm_timer #(.CNT_W(10), .HAS_CAPB(1'b0)) ptm_timer_narrow_i (
        .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(rdata_n), .avs_waitrequest(), .avs_response(),
        .count_tick(count_tick), .capture_input_pin(cap_pin), .external_clock_pin(clk_pin),
        .filter_out(flt), .filter_source_select(fss), .timer_out(),
        .match_a_pulse(), .match_p_pulse());
    ptm_pin_model ptm_pin_model_i (.ref_clk(ref_clk), .nrst(nrst), .sig(sig), .src(src),
        .capture_input_pin(cap_pin), .external_clock_pin(clk_pin), .filter_out(flt));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // narrow readback: two high bits, no second capture register
    function automatic logic [7:0] exp_n(input logic [3:0] i, input logic [7:0] d);
        if (i == PTM_IDX_CMPAH || i == PTM_IDX_PERH) return d & 8'h03;
        if (i == PTM_IDX_CAPBL || i == PTM_IDX_CAPBH) return 8'h00;
        return d;
    endfunction : exp_n
    // pin level after a compare a match
    function automatic logic exp_cmp(input logic [1:0] f, input logic oc);
        return (f == 2'h0) ? oc : (f == 2'h1) ? 1'b0 : (f == 2'h2) ? 1'b1 : ~oc;
    endfunction : exp_cmp
    // one bus transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] i, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address   <= i;
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_writedata <= {24'h00_0000, d};
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = rdata_w[7:0];
        r = rdata_n[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic tick(input int k);
        @(posedge ref_clk);
        count_tick <= 1'b1;
        repeat (k) @(posedge ref_clk);
        count_tick <= 1'b0;
    endtask : tick
    task automatic restart(input logic [7:0] ctl);
        bus(1'b1, PTM_IDX_RUN, 8'h00);
        bus(1'b1, PTM_IDX_PINCTL, ctl);
        bus(1'b1, PTM_IDX_RUN, 8'h01);
    endtask : restart
    // capture: rise at count 3, fall at 7 (4 after rise clear)
    task automatic cap_case(input logic [1:0] tc, input logic [1:0] f, input logic [1:0] s);
        logic [7:0] ea, eb, fv;
        src <= s;
        fss <= (s == 2'h2);
        fv = tc[0] ? 8'h04 : 8'h07;
        bus(1'b1, PTM_IDX_CMPAL, 8'h77);
        bus(1'b1, PTM_IDX_CAPBL, 8'h77);
        bus(1'b1, PTM_IDX_CAPCLR, {5'h00, tc, 1'b0});
        restart({2'h1, f, 2'h0, s != 2'h0, 1'b0});
        tick(3);
        sig <= 1'b1;
        repeat (4) @(posedge ref_clk);
        tick(4);
        sig <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ea = (f == 2'h3 || (tc != 2'h0 && f == 2'h0)) ? 8'h77 : (f == 2'h0) ? 8'h03 : fv;
        eb = (tc == 2'h0 || f[0]) ? 8'h77 : 8'h03;
        bus(1'b0, PTM_IDX_CMPAL, 8'h00);
        `CHK("cap_a", ea, q)
        bus(1'b0, PTM_IDX_CAPBL, 8'h00);
        `CHK("cap_b", eb, q)
        bus(1'b0, PTM_IDX_CAPCLR, 8'h00);
        if (tc != 2'h0 && f != 2'h3) `CHK("latch_flag", f == 2'h0, q[0])
        bus(1'b0, PTM_IDX_CNTL, 8'h00);
        if (f != 2'h3) `CHK("cap_clear", tc[1] ? 8'h00 : fv, q)
    endtask : cap_case
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // run time ceiling
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        {nrst, avs_read, avs_write, count_tick, sig, fss} = '0;
        {avs_address, avs_writedata, src, n_fail, samples_checked, cyc} = '0;
        avs_byteenable = 4'h1;
        seed = 32'h0000_3434;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        // reset values of all indices and one unmapped
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, (i == 11) ? 4'hF : 4'(i), 8'h00);
            `CHK("reset_w", 8'h00, q)
            `CHK("reset_n", 8'h00, r)
        end
        // random value bytes written and read back
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            a = 4'h5 + 4'(seed[10:8] % 3'h6);
            bus(1'b1, a, seed[7:0]);
            bus(1'b0, a, 8'h00);
            `CHK("rw_w", seed[7:0], q)
            `CHK("rw_n", exp_n(a, seed[7:0]), r)
        end
        bus(1'b1, PTM_IDX_CNTH, 8'hFF);
        bus(1'b0, PTM_IDX_CNTH, 8'h00);
        `CHK("count_ro", 8'h00, q)
        bus(1'b1, PTM_IDX_CAPCLR, 8'hFF);
        bus(1'b0, PTM_IDX_CAPCLR, 8'h00);
        `CHK("capclr_bits", 8'h06, q)
        // write with byte lane off is dropped
        bus(1'b1, PTM_IDX_CMPAL, 8'h03);
        avs_byteenable <= 4'h0;
        bus(1'b1, PTM_IDX_CMPAL, 8'h5A);
        avs_byteenable <= 4'h1;
        bus(1'b0, PTM_IDX_CMPAL, 8'h00);
        `CHK("be_off", 8'h03, q)
        bus(1'b1, PTM_IDX_CMPAH, 8'h00);
        bus(1'b1, PTM_IDX_PERL, 8'h10);
        bus(1'b1, PTM_IDX_PERH, 8'h00);
        // compare output over pin function, level and invert
        count_tick <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            pf = 2'(i);
            restart({2'h0, pf, i[2], i[3], 2'h0});
            `CHK("init_lvl", i[2] ^ i[3], out_w)
            while (ma_w !== 1'b1 && cyc < 19000) @(posedge ref_clk);
            repeat (2) @(posedge ref_clk);
            `CHK("match_lvl", exp_cmp(pf, i[2]) ^ i[3], out_w)
        end
        count_tick <= 1'b0;
        // counter clear source: compare a 8, period 4, six ticks
        bus(1'b1, PTM_IDX_CMPAL, 8'h08);
        bus(1'b1, PTM_IDX_PERL, 8'h04);
        for (int i = 0; i < 3; i++) begin
            restart((i == 0) ? 8'h01 : (i == 1) ? 8'h00 : 8'hA1);
            tick(6);
            bus(1'b0, PTM_IDX_CNTL, 8'h00);
            `CHK("clr_src", i == 0, q == 8'h06)
        end
        qp = q;
        bus(1'b1, PTM_IDX_RUN, 8'h00);
        tick(3);
        bus(1'b0, PTM_IDX_CNTL, 8'h00);
        `CHK("stop_hold", qp, q)
        bus(1'b1, PTM_IDX_RUN, 8'h01);
        bus(1'b0, PTM_IDX_CNTL, 8'h00);
        `CHK("run_clear", 8'h00, q)
        // forced pwm levels and single pulse start level
        for (int i = 0; i < 6; i++) begin
            pf = (i > 3) ? 2'h3 : {1'b0, i[0]};
            restart({2'h2, pf, i[1], 3'h0});
            repeat (2) @(posedge ref_clk);
            `CHK("pwm_lvl", (pf == 2'h0) ? ~i[1] : i[1], out_w)
        end
        restart({2'h3, 2'h1, 2'h3, 2'h0});
        repeat (2) @(posedge ref_clk);
        `CHK("tmr_out", 1'b0, out_w)
        bus(1'b1, PTM_IDX_PERL, 8'h40);
        for (int i = 0; i < 24; i++) cap_case(2'(i), 2'(i >> 2), 2'(i / 8));
        test_done();
    end
endmodule : periodic_timer_pin_and_compare_control_tb_top
`default_nettype wire
